// [dv/power_state_output_control_tb.sv]
// Self-checking bench joining the supply device and microcontroller ends
`timescale 1ns/1ps
module power_state_output_control_tb;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic supply_ok = 1'b0, step_up_select_pin = 1'b0, vin_low = 1'b0, core_sel = 1'b1;
	logic go_norm = 1'b0, go_stby = 1'b0, wake = 1'b0, send = 1'b0;
	logic [7:0] cfg = 8'h00;
	logic [7:0] c;
	logic [31:0] seed = 32'h64EA7DAE;
	logic [1:0] state, safe, trk;
	logic pre, step_up, mcu_reg, stby_reg, comm, core_adj, vref, wake_t, wdg, err, busy, rst_n;
	int n_fail = 0;
	int compares = 0;
	always #12.5 clk_in = ~clk_in;
	pso_if u_pso_if();
	pso_device #(.RD_CYCLES(4)) u_pso_device(.clk_in(clk_in), .resetn_in(resetn_in),
		.link(u_pso_if), .supply_ok_in(supply_ok), .step_up_select_pin_in(step_up_select_pin),
		.vin_low_in(vin_low), .core_supply_select_pin_in(core_sel), .go_normal_in(go_norm),
		.go_standby_in(go_stby), .wake_in(wake), .state_out(state),
		.pre_regulator_en_out(pre), .step_up_en_out(step_up), .mcu_regulator_en_out(mcu_reg),
		.standby_regulator_en_out(stby_reg), .comm_regulator_en_out(comm),
		.core_supply_adjust_out(core_adj), .voltage_reference_en_out(vref),
		.tracker_enables_out(trk), .wake_timer_en_out(wake_t), .watchdog_en_out(wdg),
		.error_monitor_en_out(err));
	pso_host #(.HALF_CYCLES(8)) u_pso_host(.clk_in(clk_in), .resetn_in(resetn_in),
		.link(u_pso_if), .cfg_in(cfg), .send_in(send), .busy_out(busy),
		.mcu_reset_n_out(rst_n), .safe_state_out(safe));
	pso_sva #(.RD_CYCLES(4)) u_pso_sva(.clk_in(clk_in), .resetn_in(resetn_in),
		.supply_ok_in(supply_ok), .mcu_reset_n_in(u_pso_if.mcu_reset_n),
		.safe_state_outputs_in(u_pso_if.safe_state_outputs), .state_in(state),
		.pre_regulator_en_in(pre), .mcu_regulator_en_in(mcu_reg),
		.standby_regulator_en_in(stby_reg), .comm_regulator_en_in(comm),
		.core_supply_adjust_in(core_adj), .voltage_reference_en_in(vref),
		.tracker_enables_in(trk), .wake_timer_en_in(wake_t), .watchdog_en_in(wdg),
		.error_monitor_en_in(err));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Wake timer only counts in standby; supervision only outside it
	function automatic logic [7:0] exp_cfg(input logic [7:0] v, input logic stby);
		return stby ? (v & 8'h81) : (v & 8'h7F);
	endfunction
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Which: 0 waits on busy, 1 on the synchronised reset
	task automatic wait_for(input int which, input logic v);
		logic s;
		s = (which == 0) ? busy : rst_n;
		for (int i = 0; i < 600 && s !== v; i++) begin
			@(negedge clk_in);
			s = (which == 0) ? busy : rst_n;
		end
		if (s !== v) begin
			n_fail++;
			$display("CHECK FAILED wait expected %0h seen %0h", v, s);
			conclude();
		end
	endtask
	// Which: 0 go normal, 1 go standby, 2 wake
	task automatic pulse(input int which);
		@(posedge clk_in);
		go_norm <= (which == 0);
		go_stby <= (which == 1);
		wake <= (which == 2);
		@(posedge clk_in);
		go_norm <= 1'b0;
		go_stby <= 1'b0;
		wake <= 1'b0;
		repeat (6) @(negedge clk_in);
	endtask
	task automatic send_cfg(input logic [7:0] v);
		@(posedge clk_in);
		cfg <= v;
		send <= 1'b1;
		@(posedge clk_in);
		send <= 1'b0;
		@(negedge clk_in);
		wait_for(0, 1'b0);
		repeat (8) @(negedge clk_in);
	endtask
	task automatic check_norm(input logic [7:0] v);
		logic [7:0] en;
		en = {wake_t, err, wdg, trk, vref, comm, stby_reg};
		check("enables", en, exp_cfg(v, 1'b0));
		check("rails", {pre, mcu_reg, step_up}, {2'h3, step_up_select_pin & vin_low});
		check("link", {rst_n, safe}, 3'h7);
		check("state", state, 2'h2);
	endtask
	task automatic check_stby(input logic [7:0] v);
		logic [7:0] en;
		en = {wake_t, err, wdg, trk, vref, comm, stby_reg};
		check("enables", en, exp_cfg(v, 1'b1));
		check("rails", {pre, mcu_reg, core_adj, step_up}, 4'h0);
		check("link", {rst_n, safe}, 3'h0);
		check("state", state, 2'h3);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(negedge clk_in);
		check("init link", {rst_n, safe}, 3'h0);
		@(posedge clk_in);
		supply_ok <= 1'b1;
		repeat (5) @(negedge clk_in);
		check("early reset", rst_n, 1'b0);
		wait_for(1, 1'b1);
		check("init safe", safe, 2'h0);
		$display("test init done");
		// Strap flips after release and must be ignored
		@(posedge clk_in);
		core_sel <= 1'b0;
		pulse(0);
		check("core adjust", core_adj, 1'b1);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			// Last frame clears the standby bit so the power-on default stands apart
			c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 7) ? {seed[7:1], 1'b0} : seed[7:0];
			@(posedge clk_in);
			step_up_select_pin <= seed[8];
			vin_low <= seed[9];
			send_cfg(c);
			check_norm(c);
		end
		$display("test normal done");
		pulse(1);
		check_stby(c);
		// Frames sent in standby are dropped
		send_cfg(~c);
		check_stby(c);
		$display("test standby done");
		pulse(2);
		check("kept stby", stby_reg, c[0]);
		wait_for(1, 1'b1);
		pulse(0);
		check_norm(c);
		$display("test rewake done");
		// Power-on reset in mid-run restores the default standby setting
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(negedge clk_in);
		check("por state", state, 2'h1);
		check("por default", stby_reg, pso_pkg::CFG_RESET[pso_pkg::CFG_STBY]);
		check("por link", {rst_n, safe}, 3'h0);
		$display("test por done");
		conclude();
	end
endmodule

// [dv/pso_sva.sv]
// Assertions on the supply link and the decoded enables
`timescale 1ns/1ps
module pso_sva #(
	parameter int RD_CYCLES = pso_pkg::RD_CYC
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic supply_ok_in,
	input wire logic mcu_reset_n_in,
	input wire logic [1:0] safe_state_outputs_in,
	input wire logic [1:0] state_in,
	input wire logic pre_regulator_en_in,
	input wire logic mcu_regulator_en_in,
	input wire logic standby_regulator_en_in,
	input wire logic comm_regulator_en_in,
	input wire logic core_supply_adjust_in,
	input wire logic voltage_reference_en_in,
	input wire logic [1:0] tracker_enables_in,
	input wire logic wake_timer_en_in,
	input wire logic watchdog_en_in,
	input wire logic error_monitor_en_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	// ------------------------------------------------------------
	// Supply good run length
	// ------------------------------------------------------------
	// Saturates so a long run never wraps back below the delay
	logic [15:0] sup_run_q;
	logic [15:0] sup_run_d;

	always_comb begin
		sup_run_d = sup_run_q;
		if (!supply_ok_in) begin
			sup_run_d = 16'h0000;
		end else if (sup_run_q != 16'hFFFF) begin
			sup_run_d = sup_run_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sup_run_q <= 16'h0000;
		end else begin
			sup_run_q <= sup_run_d;
		end
	end

	// ------------------------------------------------------------
	// State decode
	// ------------------------------------------------------------
	init_safe_a: assert property (state_in == 2'h1 |-> safe_state_outputs_in == 2'h0)
		else $error("safe outputs high in init");
	// Pin synchroniser delay only lengthens the run seen here
	rst_delay_a: assert property ($rose(mcu_reset_n_in) && state_in == 2'h1 |->
		sup_run_q >= 16'(RD_CYCLES)) else $error("reset released early");
	norm_link_a: assert property (state_in == 2'h2 |->
		mcu_reset_n_in && safe_state_outputs_in == 2'h3) else $error("normal link levels wrong");
	norm_rails_a: assert property (state_in == 2'h2 |->
		pre_regulator_en_in && mcu_regulator_en_in && !wake_timer_en_in)
		else $error("normal rails wrong");
	stby_link_a: assert property (state_in == 2'h3 |->
		!mcu_reset_n_in && safe_state_outputs_in == 2'h0) else $error("standby link levels wrong");
	stby_off_a: assert property (state_in == 2'h3 |-> !(pre_regulator_en_in |
		mcu_regulator_en_in | comm_regulator_en_in | core_supply_adjust_in |
		voltage_reference_en_in | (|tracker_enables_in))) else $error("standby rail on");
	stby_super_a: assert property (state_in == 2'h3 |->
		!watchdog_en_in && !error_monitor_en_in) else $error("standby supervision on");
	stby_keep_a: assert property (state_in == 2'h3 |->
		$stable(standby_regulator_en_in)) else $error("standby regulator changed");
endmodule

// [hdl/pso_device.sv]
// Supply device end: power state register and output decode
`timescale 1ns/1ps
module pso_device #(
	parameter int RD_CYCLES = pso_pkg::RD_CYC
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	pso_if.dev link,
	input wire logic supply_ok_in,
	input wire logic step_up_select_pin_in,
	input wire logic vin_low_in,
	input wire logic core_supply_select_pin_in,
	input wire logic go_normal_in,
	input wire logic go_standby_in,
	input wire logic wake_in,
	output logic [1:0] state_out,
	output logic pre_regulator_en_out,
	output logic step_up_en_out,
	output logic mcu_regulator_en_out,
	output logic standby_regulator_en_out,
	output logic comm_regulator_en_out,
	output logic core_supply_adjust_out,
	output logic voltage_reference_en_out,
	output logic [1:0] tracker_enables_out,
	output logic wake_timer_en_out,
	output logic watchdog_en_out,
	output logic error_monitor_en_out
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [pso_pkg::SY_W-1:0] pins;
	logic [pso_pkg::SY_W-1:0] s1_q;
	logic [pso_pkg::SY_W-1:0] s2_q;
	logic [pso_pkg::SY_W-1:0] s3_q;
	logic [pso_pkg::SY_W-1:0] f_q;
	logic [pso_pkg::SY_W-1:0] f_d;

	assign pins = {core_supply_select_pin_in, vin_low_in, step_up_select_pin_in,
		supply_ok_in, link.mosi, link.cs_n, link.sck};

	// A change counts only once the second and third stage agree
	always_comb begin
		for (int i = 0; i < pso_pkg::SY_W; i++) begin
			f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_q <= pso_pkg::SY_RESET;
			s2_q <= pso_pkg::SY_RESET;
			s3_q <= pso_pkg::SY_RESET;
			f_q <= pso_pkg::SY_RESET;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end

	// ------------------------------------------------------------
	// Serial configuration receiver
	// ------------------------------------------------------------
	pso_pkg::pso_state_e st_q;
	pso_pkg::pso_state_e st_d;
	logic sck_p_q;
	logic csn_p_q;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic cfg_open;

	// Commands are only heard while the controller is powered
	assign cfg_open = (st_q == pso_pkg::PSO_INIT) || (st_q == pso_pkg::PSO_NORMAL);

	always_comb begin
		sh_d = sh_q;
		cnt_d = cnt_q;
		cfg_d = cfg_q;
		if (f_q[pso_pkg::SY_CSN]) begin
			cnt_d = 4'h0;
		end else if (f_q[pso_pkg::SY_SCK] && !sck_p_q && cnt_q != 4'hF) begin
			sh_d = {sh_q[6:0], f_q[pso_pkg::SY_MOSI]};
			cnt_d = cnt_q + 4'h1;
		end
		// Frame commits on chip select release, only if whole
		if (f_q[pso_pkg::SY_CSN] && !csn_p_q && cfg_open
				&& cnt_q == 4'(pso_pkg::FRAME_BITS)) begin
			cfg_d = sh_q;
		end
		if (st_q == pso_pkg::PSO_POWERDOWN) begin
			cfg_d = pso_pkg::CFG_RESET;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sck_p_q <= 1'b0;
			csn_p_q <= 1'b1;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			cfg_q <= pso_pkg::CFG_RESET;
		end else begin
			sck_p_q <= f_q[pso_pkg::SY_SCK];
			csn_p_q <= f_q[pso_pkg::SY_CSN];
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			cfg_q <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// Power state and reset delay
	// ------------------------------------------------------------
	logic [15:0] rd_q;
	logic [15:0] rd_d;
	logic rel_q;
	logic rel_d;
	logic core_q;
	logic core_d;
	logic sup_ok;

	assign sup_ok = f_q[pso_pkg::SY_SUPOK];

	always_comb begin
		st_d = st_q;
		rd_d = rd_q;
		rel_d = rel_q;
		core_d = core_q;
		case (st_q)
			pso_pkg::PSO_POWERDOWN: begin
				st_d = pso_pkg::PSO_INIT;
				rd_d = 16'h0000;
				rel_d = 1'b0;
			end
			pso_pkg::PSO_INIT: begin
				// Pin is latched only until reset is released
				if (!rel_q) begin
					core_d = f_q[pso_pkg::SY_CORE];
				end
				// A supply dip restarts the whole delay
				if (!sup_ok) begin
					rd_d = 16'h0000;
					rel_d = 1'b0;
				end else if (!rel_q) begin
					if (rd_q == 16'(RD_CYCLES - 1)) begin
						rel_d = 1'b1;
					end else begin
						rd_d = rd_q + 16'h0001;
					end
				end
				if (go_normal_in && rel_q) begin
					st_d = pso_pkg::PSO_NORMAL;
				end
			end
			pso_pkg::PSO_NORMAL: begin
				if (go_standby_in) begin
					st_d = pso_pkg::PSO_STANDBY;
				end
			end
			pso_pkg::PSO_STANDBY: begin
				if (wake_in) begin
					st_d = pso_pkg::PSO_INIT;
					rd_d = 16'h0000;
					rel_d = 1'b0;
				end
			end
			default: begin
				st_d = pso_pkg::PSO_POWERDOWN;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= pso_pkg::PSO_POWERDOWN;
			rd_q <= 16'h0000;
			rel_q <= 1'b0;
			core_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rd_q <= rd_d;
			rel_q <= rel_d;
			core_q <= core_d;
		end
	end

	// ------------------------------------------------------------
	// Output decode
	// ------------------------------------------------------------
	// Decoded straight from state so a state change moves every enable in one cycle
	always_comb begin
		state_out = st_q;
		pre_regulator_en_out = 1'b0;
		mcu_regulator_en_out = 1'b0;
		comm_regulator_en_out = 1'b0;
		core_supply_adjust_out = 1'b0;
		voltage_reference_en_out = 1'b0;
		tracker_enables_out = 2'b00;
		wake_timer_en_out = 1'b0;
		watchdog_en_out = 1'b0;
		error_monitor_en_out = 1'b0;
		link.mcu_reset_n = 1'b0;
		link.safe_state_outputs = 2'b00;
		standby_regulator_en_out = 1'b0;
		case (st_q)
			pso_pkg::PSO_INIT,
			pso_pkg::PSO_NORMAL: begin
				pre_regulator_en_out = 1'b1;
				mcu_regulator_en_out = 1'b1;
				standby_regulator_en_out = cfg_q[pso_pkg::CFG_STBY];
				comm_regulator_en_out = cfg_q[pso_pkg::CFG_COMM];
				voltage_reference_en_out = cfg_q[pso_pkg::CFG_VREF];
				tracker_enables_out = {cfg_q[pso_pkg::CFG_TRK2],
					cfg_q[pso_pkg::CFG_TRK1]};
				core_supply_adjust_out = core_q;
				wake_timer_en_out = 1'b0;
				watchdog_en_out = cfg_q[pso_pkg::CFG_WDG];
				error_monitor_en_out = cfg_q[pso_pkg::CFG_ERRMON];
				if (st_q == pso_pkg::PSO_NORMAL) begin
					link.mcu_reset_n = 1'b1;
					link.safe_state_outputs = 2'b11;
				end else begin
					link.mcu_reset_n = rel_q;
					link.safe_state_outputs = 2'b00;
				end
			end
			pso_pkg::PSO_STANDBY: begin
				standby_regulator_en_out = cfg_q[pso_pkg::CFG_STBY];
				wake_timer_en_out = cfg_q[pso_pkg::CFG_WAKE];
				// Everything else stays at its off default
				link.mcu_reset_n = 1'b0;
				link.safe_state_outputs = 2'b00;
			end
			default: begin
				standby_regulator_en_out = 1'b0;
			end
		endcase
		// Step-up only when strapped in and input is low
		step_up_en_out = pre_regulator_en_out && f_q[pso_pkg::SY_STU]
			&& f_q[pso_pkg::SY_VINLO];
	end

endmodule

// [hdl/pso_host.sv]
// Microcontroller end: sends configuration frames, watches reset
`timescale 1ns/1ps
module pso_host #(
	parameter int HALF_CYCLES = pso_pkg::SCK_HALF_CYC
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	pso_if.mcu link,
	input wire logic [7:0] cfg_in,
	input wire logic send_in,
	output logic busy_out,
	output logic mcu_reset_n_out,
	output logic [1:0] safe_state_out
);

	// ------------------------------------------------------------
	// Serial clock divider and frame sender
	// ------------------------------------------------------------
	pso_pkg::pso_host_e hs_q;
	pso_pkg::pso_host_e hs_d;
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [2:0] n_q;
	logic [2:0] n_d;
	logic tick;

	assign tick = (div_q == 8'(HALF_CYCLES - 1));
	assign busy_out = (hs_q != pso_pkg::PSO_H_IDLE);
	assign link.sck = (hs_q == pso_pkg::PSO_H_HIGH);
	assign link.cs_n = (hs_q == pso_pkg::PSO_H_IDLE) || (hs_q == pso_pkg::PSO_H_GAP);
	assign link.mosi = sh_q[7];

	always_comb begin
		hs_d = hs_q;
		sh_d = sh_q;
		n_d = n_q;
		div_d = (tick || hs_q == pso_pkg::PSO_H_IDLE) ? 8'h00 : div_q + 8'h01;
		case (hs_q)
			pso_pkg::PSO_H_IDLE: begin
				if (send_in) begin
					sh_d = cfg_in;
					n_d = 3'h0;
					hs_d = pso_pkg::PSO_H_LOW;
				end
			end
			pso_pkg::PSO_H_LOW: begin
				if (tick) begin
					hs_d = pso_pkg::PSO_H_HIGH;
				end
			end
			pso_pkg::PSO_H_HIGH: begin
				// Data moves on the falling edge, device samples on rising
				if (tick) begin
					n_d = n_q + 3'h1;
					if (n_q == 3'h7) begin
						hs_d = pso_pkg::PSO_H_TAIL;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						hs_d = pso_pkg::PSO_H_LOW;
					end
				end
			end
			pso_pkg::PSO_H_TAIL: begin
				if (tick) begin
					hs_d = pso_pkg::PSO_H_GAP;
				end
			end
			pso_pkg::PSO_H_GAP: begin
				// Gap lets the device see chip select high before the next frame
				if (tick) begin
					hs_d = pso_pkg::PSO_H_IDLE;
				end
			end
			default: begin
				hs_d = pso_pkg::PSO_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hs_q <= pso_pkg::PSO_H_IDLE;
			div_q <= 8'h00;
			sh_q <= 8'h00;
			n_q <= 3'h0;
		end else begin
			hs_q <= hs_d;
			div_q <= div_d;
			sh_q <= sh_d;
			n_q <= n_d;
		end
	end

	// ------------------------------------------------------------
	// Reset and safe state input synchronisers
	// ------------------------------------------------------------
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	logic [2:0] f_q;
	logic [2:0] f_d;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
			f_q <= 3'h0;
		end else begin
			s1_q <= {link.safe_state_outputs, link.mcu_reset_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
		end
	end

	assign mcu_reset_n_out = f_q[0];
	assign safe_state_out = f_q[2:1];

endmodule

// [hdl/pso_if.sv]
// Link between the supply device and the microcontroller
`timescale 1ns/1ps
interface pso_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic mcu_reset_n;
	logic [1:0] safe_state_outputs;

	modport dev (
		input sck,
		input cs_n,
		input mosi,
		output mcu_reset_n,
		output safe_state_outputs
	);

	modport mcu (
		output sck,
		output cs_n,
		output mosi,
		input mcu_reset_n,
		input safe_state_outputs
	);
endinterface

// [hdl/pso_pkg.sv]
// Shared constants and types for the power state output control block
package pso_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int T_RD_NS = 10000;
	localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
	localparam int SCK_HALF_CYC = 8;

	// ------------------------------------------------------------
	// Configuration frame layout
	// ------------------------------------------------------------
	localparam int FRAME_BITS = 8;
	localparam int CFG_STBY = 0;
	localparam int CFG_COMM = 1;
	localparam int CFG_VREF = 2;
	localparam int CFG_TRK1 = 3;
	localparam int CFG_TRK2 = 4;
	localparam int CFG_WDG = 5;
	localparam int CFG_ERRMON = 6;
	localparam int CFG_WAKE = 7;
	localparam logic [7:0] CFG_RESET = 8'h7F;

	// ------------------------------------------------------------
	// Pin synchroniser layout
	// ------------------------------------------------------------
	localparam int SY_SCK = 0;
	localparam int SY_CSN = 1;
	localparam int SY_MOSI = 2;
	localparam int SY_SUPOK = 3;
	localparam int SY_STU = 4;
	localparam int SY_VINLO = 5;
	localparam int SY_CORE = 6;
	localparam int SY_W = 7;
	localparam logic [6:0] SY_RESET = 7'h02;

	typedef enum logic [1:0] {
		PSO_POWERDOWN,
		PSO_INIT,
		PSO_NORMAL,
		PSO_STANDBY
	} pso_state_e;

	typedef enum logic [2:0] {
		PSO_H_IDLE,
		PSO_H_LOW,
		PSO_H_HIGH,
		PSO_H_TAIL,
		PSO_H_GAP
	} pso_host_e;

endpackage
